/* rtl/omsm_defs.vh */
// Constants of the operating mode state machine
`ifndef OMSM_DEFS_VH
`define OMSM_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define OMSM_CLK_PERIOD_NS    5
`define OMSM_RESET_DELAY_US   10
`define OMSM_LONG_WINDOW_MS   200
`define OMSM_WD_PERIOD_MS     20
// Least time rounds up
`define OMSM_RD_CYCLES ((`OMSM_RESET_DELAY_US*1000+`OMSM_CLK_PERIOD_NS-1)/`OMSM_CLK_PERIOD_NS)
// Deadlines round down
`define OMSM_LW_CYCLES ((`OMSM_LONG_WINDOW_MS*1000000)/`OMSM_CLK_PERIOD_NS)
`define OMSM_WD_CYCLES ((`OMSM_WD_PERIOD_MS*1000000)/`OMSM_CLK_PERIOD_NS)

// ****************************************
// Serial frame layout
// ****************************************
`define OMSM_FRAME_BITS       16
`define OMSM_FRM_WRITE_BIT    15
`define OMSM_FRM_ADDR_MSB     14
`define OMSM_FRM_ADDR_LSB     8
`define OMSM_FRM_DATA_MSB     7

// ****************************************
// Register addresses
// ****************************************
`define OMSM_ADDR_MODE_CTRL   7'h01
`define OMSM_ADDR_WATCHDOG_CONTROL_REG     7'h02
`define OMSM_ADDR_HARDWARE_CONTROL_REG     7'h03
`define OMSM_ADDR_SYS_CTRL    7'h04
`define OMSM_ADDR_STAT_CLR    7'h05

// ****************************************
// Fields and codes
// ****************************************
`define OMSM_MODE_NORMAL      3'h0
`define OMSM_MODE_SLEEP       3'h1
`define OMSM_MODE_STOP        3'h2
`define OMSM_MODE_SOFT_RESET  3'h3
`define OMSM_WD_REFRESH_BIT   0
`define OMSM_WD_LIMIT_BIT     1
`define OMSM_HW_THRESH_BIT    0
`define OMSM_CLR_SPI_BIT      0
`define OMSM_CLR_WD_BIT       1
`define OMSM_CLR_UV_BIT       2
`define OMSM_CLR_WAKE_BIT     3
`define OMSM_CLR_FS_BIT       4
`define OMSM_THRESH_RESET     1'h1
`define OMSM_RST_LIMIT_COUNT  2'h3

`endif

/* rtl/omsm_spi_rx.v */
// Serial frame receiver with status shift-out
`timescale 1ns/1ps
`default_nettype none
`include "omsm_defs.vh"

module omsm_spi_rx #(
    parameter FRAME_BITS = `OMSM_FRAME_BITS
) (
    // Clock and reset
    input  wire                  clock,
    input  wire                  resetn,
    // Serial pins
    input  wire                  spi_sck,
    input  wire                  spi_csn,
    input  wire                  spi_mosi,
    output wire                  spi_miso,
    output wire                  spi_miso_oe,
    // Frame side
    input  wire [FRAME_BITS-1:0] status_word,
    output reg                   frame_valid,
    output reg                   frame_error,
    output reg  [FRAME_BITS-1:0] frame_word
);

    localparam CW = $clog2(FRAME_BITS) + 1;
    localparam [CW-1:0] FULL = FRAME_BITS;

    reg [2:0]            pin_meta;
    reg [2:0]            pin_sync;
    reg                  sck_last;
    reg                  csn_last;
    reg [CW-1:0]         bit_cnt;
    reg [FRAME_BITS-1:0] rx_shift;
    reg [FRAME_BITS-1:0] tx_shift;

    wire sck_s  = pin_sync[0];
    wire csn_s  = pin_sync[1];
    wire mosi_s = pin_sync[2];
    wire sck_rise = sck_s & ~sck_last & ~csn_s;
    wire sck_fall = ~sck_s & sck_last & ~csn_s;

    assign spi_miso    = tx_shift[FRAME_BITS-1];
    assign spi_miso_oe = ~csn_s;

    // ****************************************
    // Pin synchronisers and frame assembly
    // ****************************************
    always @(posedge clock) begin
        if (!resetn) begin
            pin_meta    <= 3'h2;
            pin_sync    <= 3'h2;
            sck_last    <= 1'h0;
            csn_last    <= 1'h1;
            bit_cnt     <= {CW{1'b0}};
            rx_shift    <= {FRAME_BITS{1'b0}};
            tx_shift    <= {FRAME_BITS{1'b0}};
            frame_valid <= 1'h0;
            frame_error <= 1'h0;
            frame_word  <= {FRAME_BITS{1'b0}};
        end else begin
            pin_meta    <= {spi_mosi, spi_csn, spi_sck};
            pin_sync    <= pin_meta;
            sck_last    <= sck_s;
            csn_last    <= csn_s;
            frame_valid <= 1'h0;
            frame_error <= 1'h0;
            if (!csn_s && csn_last) begin
                bit_cnt  <= {CW{1'b0}};
                tx_shift <= status_word;
            end else if (sck_rise) begin
                rx_shift <= {rx_shift[FRAME_BITS-2:0], mosi_s};
                if (bit_cnt != {CW{1'b1}})
                    bit_cnt <= bit_cnt + 1'b1;
            end else if (sck_fall) begin
                tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
            end
            // Only a frame of exactly the full length counts as a command
            if (csn_s && !csn_last) begin
                if (bit_cnt == FULL) begin
                    frame_valid <= 1'h1;
                    frame_word  <= rx_shift;
                end else begin
                    frame_error <= 1'h1;
                end
            end
        end
    end

endmodule // omsm_spi_rx
`default_nettype wire

/* rtl/omsm_top.v */
// Operating mode state machine of the supply companion device
// Functional notes
// RULE1: Init mode at power-up and soft reset; six operating modes.
// RULE2: Restart goes to normal alone once failure cleared and delay expired.
// RULE3: Critical fault enters fail-safe, regulator off, until wake without overtemperature.
// RULE4: Stop mode saves power with main regulator still on.
// RULE5: Sleep mode switches main regulator off.
// RULE6: Strap low in init gives development mode, watchdog halted.
// RULE7: Control and diagnosis only through 16-bit serial frames.
// RULE8: Mode field write changes mode; restart clears the field.
// RULE9: In init strap pin is input with pull-up, sampled for configuration.
// RULE10: Configuration 0 never resets on watchdog failure.
// RULE11: Configuration 1 restarts on first missed trigger, fail-safe outputs on.
// RULE12: Configuration 3 restarts on second missed trigger, fail-safe outputs on.
// RULE13: Threshold-select bit in hardware control picks configuration 1 or 3.
// RULE14: After threshold, one reset delay, release reset, start long window.
// RULE15: Any frame in init, even illegal, moves to normal.
// RULE16: No trigger in long window flags failure, restarts, one reset; with thresh_sel 0 the code only counts it as a first miss.
// RULE17: Reset limit set stops resets after three consecutive watchdog resets.
// RULE18: Wake events in init are discarded.
// RULE19: Host should service and set up the watchdog first.
// RULE20: No undervoltage flag or fail-safe during power-up below thresholds.
// RULE21: Reset low below threshold, released one reset delay after.
// RULE22: Stop mode rejects most writes and flags serial error.
// RULE23: Stop to sleep request is refused, flags error, enters restart.
// RULE24: Reset delay and long window timed by counters, lengths are parameters.
`timescale 1ns/1ps
`default_nettype none
`include "omsm_defs.vh"

module omsm_top #(
    parameter [31:0] RESET_DELAY_CYCLES = `OMSM_RD_CYCLES,
    parameter [31:0] LONG_WINDOW_CYCLES = `OMSM_LW_CYCLES,
    parameter [31:0] WD_PERIOD_CYCLES   = `OMSM_WD_CYCLES
) (
    // Clock and reset
    input  wire        clock,
    input  wire        resetn,
    // Serial link
    input  wire        spi_sck,
    input  wire        spi_csn,
    input  wire        spi_mosi,
    output wire        spi_miso,
    output wire        spi_miso_oe,
    // Supply and fault monitors
    input  wire        main_supply_undervoltage,
    input  wire        battery_uv_timeout,
    input  wire        severe_thermal_shutdown,
    input  wire        main_supply_short,
    input  wire        wake_input_pin,
    // Strap and fail-safe pin
    input  wire        failsafe_strap_pin_in,
    output wire        failsafe_strap_pin_out,
    output wire        failsafe_strap_pin_oe,
    output wire        strap_pullup_enable,
    // Mode and status
    output wire        reset_output_pin_n,
    output wire        main_regulator_output,
    output wire        low_power_stop,
    output wire [5:0]  current_mode,
    output wire [2:0]  operating_mode_select,
    output wire        restart_threshold_state,
    output wire        watchdog_halted,
    output wire        failsafe_outputs,
    output wire        spi_error_flag,
    output wire        watchdog_fail_flag,
    output wire        undervoltage_flag,
    output wire        wake_flag
);

    localparam [5:0] ST_INIT     = 6'h01;
    localparam [5:0] ST_NORMAL   = 6'h02;
    localparam [5:0] ST_STOP     = 6'h04;
    localparam [5:0] ST_SLEEP    = 6'h08;
    localparam [5:0] ST_RESTART  = 6'h10;
    localparam [5:0] ST_FAILSAFE = 6'h20;

    reg  [5:0]  state;
    reg  [5:0]  next_state;
    reg  [5:0]  mon_meta;
    reg  [5:0]  mon_sync;
    reg         wake_last;
    reg  [31:0] rd_cnt;
    reg  [31:0] wd_cnt;
    reg  [1:0]  miss_cnt;
    reg  [1:0]  rst_cnt;
    reg         released;
    reg         dev_mode;
    reg  [2:0]  mode_sel;
    reg         thresh_sel;
    reg         reset_limit;
    reg         spi_err;
    reg         wd_fail;
    reg         uv_flag;
    reg         wk_flag;
    reg         fs_active;

    wire        frame_valid;
    wire        frame_error;
    wire [15:0] frame_word;

    wire uv     = mon_sync[0];
    wire bat_lo = mon_sync[1];
    wire tsd    = mon_sync[2];
    wire vshort = mon_sync[3];
    wire wake   = mon_sync[4];
    wire strap  = mon_sync[5];

    wire in_init = state[0];
    wire in_norm = state[1];
    wire in_stop = state[2];
    wire in_slp  = state[3];
    wire in_rst  = state[4];
    wire in_fs   = state[5];

    wire crit     = tsd | vshort;
    wire wake_evt = wake & ~wake_last;
    wire powerup  = in_init & ~released & uv & bat_lo;

    // ****************************************
    // Frame receiver and command decode
    // ****************************************
    omsm_spi_rx #(
        .FRAME_BITS (`OMSM_FRAME_BITS)
    ) u_spi_rx (
        .clock       (clock),
        .resetn      (resetn),
        .spi_sck     (spi_sck),
        .spi_csn     (spi_csn),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .status_word ({spi_err, wd_fail, uv_flag, wk_flag, fs_active, dev_mode,
                       thresh_sel, reset_limit, 2'h0, state}),
        .frame_valid (frame_valid),
        .frame_error (frame_error),
        .frame_word  (frame_word)
    );

    wire       fr_write = frame_word[`OMSM_FRM_WRITE_BIT];
    wire [6:0] fr_addr  = frame_word[`OMSM_FRM_ADDR_MSB:`OMSM_FRM_ADDR_LSB];
    wire [7:0] fr_data  = frame_word[`OMSM_FRM_DATA_MSB:0];
    wire [2:0] fr_mode  = fr_data[2:0];

    wire wr_any  = frame_valid & fr_write;
    wire wr_mode = wr_any & (fr_addr == `OMSM_ADDR_MODE_CTRL);
    wire wr_wd   = wr_any & (fr_addr == `OMSM_ADDR_WATCHDOG_CONTROL_REG);
    wire wr_hw   = wr_any & (fr_addr == `OMSM_ADDR_HARDWARE_CONTROL_REG);
    wire wr_sys  = wr_any & (fr_addr == `OMSM_ADDR_SYS_CTRL);
    wire wr_clr  = wr_any & (fr_addr == `OMSM_ADDR_STAT_CLR);

    wire stop_ok = ~fr_write | wr_sys | wr_clr                        // RULE22
                 | (wr_wd & fr_data[`OMSM_WD_REFRESH_BIT])
                 | (wr_mode & ((fr_mode == `OMSM_MODE_NORMAL)
                             | (fr_mode == `OMSM_MODE_SOFT_RESET)));
    wire stop_rej = frame_valid & in_stop & ~stop_ok;                 // RULE22
    // Sleep ignores the link entirely; stop only passes its exempt set
    wire cmd_ok   = frame_valid & ~in_slp & (~in_stop | stop_ok);     // RULE7
    wire sleep_from_stop = stop_rej & wr_mode & (fr_mode == `OMSM_MODE_SLEEP); // RULE23

    wire refresh = cmd_ok & wr_wd & fr_data[`OMSM_WD_REFRESH_BIT];
    wire mode_cmd = cmd_ok & wr_mode & ~in_init;

    // ****************************************
    // Watchdog
    // ****************************************
    // Development mode halts the counter, so configuration 0 never trips
    wire wd_run    = ~dev_mode & released & (in_init | in_norm | in_stop); // RULE6 RULE10
    wire wd_expire = wd_run & (wd_cnt == 32'h0) & ~refresh;
    wire [1:0] miss_need = thresh_sel ? 2'h1 : 2'h2;                  // RULE11 RULE12
    wire wd_trip   = wd_expire & ((miss_cnt + 2'h1) >= miss_need);    // RULE16
    wire wd_capped = reset_limit & (rst_cnt == `OMSM_RST_LIMIT_COUNT); // RULE17
    wire wd_reset  = wd_trip & ~wd_capped;

    wire init_release = in_init & ~released & ~uv & (rd_cnt == 32'h0); // RULE14 RULE21

    // ****************************************
    // Mode transitions
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (crit)
                    next_state = ST_FAILSAFE;
                else if (wd_reset)
                    next_state = ST_RESTART;
                else if (released && (frame_valid || frame_error))
                    next_state = ST_NORMAL;                           // RULE15
            end
            ST_NORMAL, ST_STOP: begin
                if (crit)
                    next_state = ST_FAILSAFE;                         // RULE3
                else if (uv || wd_reset || sleep_from_stop)
                    next_state = ST_RESTART;                          // RULE16 RULE23
                else if (mode_cmd && fr_mode == `OMSM_MODE_SOFT_RESET)
                    next_state = ST_INIT;                             // RULE1
                else if (mode_cmd && fr_mode == `OMSM_MODE_NORMAL)
                    next_state = ST_NORMAL;                           // RULE8
                else if (mode_cmd && in_norm && fr_mode == `OMSM_MODE_STOP)
                    next_state = ST_STOP;                             // RULE8
                else if (mode_cmd && in_norm && fr_mode == `OMSM_MODE_SLEEP)
                    next_state = ST_SLEEP;                            // RULE8
            end
            ST_SLEEP: begin
                if (crit)
                    next_state = ST_FAILSAFE;
                else if (wake_evt)
                    next_state = ST_RESTART;
            end
            ST_RESTART: begin
                if (crit)
                    next_state = ST_FAILSAFE;
                else if (!uv && rd_cnt == 32'h0)
                    next_state = ST_NORMAL;                           // RULE2
            end
            ST_FAILSAFE: begin
                if (wake_evt && !tsd)
                    next_state = ST_RESTART;                          // RULE3
            end
            default: next_state = ST_INIT;
        endcase
    end

    // ****************************************
    // State, timers and configuration
    // ****************************************
    always @(posedge clock) begin
        if (!resetn) begin
            state       <= ST_INIT;                                   // RULE1
            mon_meta    <= 6'h20;
            mon_sync    <= 6'h20;
            wake_last   <= 1'h0;
            rd_cnt      <= RESET_DELAY_CYCLES;
            wd_cnt      <= LONG_WINDOW_CYCLES;
            miss_cnt    <= 2'h0;
            rst_cnt     <= 2'h0;
            released    <= 1'h0;
            dev_mode    <= 1'h0;
            mode_sel    <= `OMSM_MODE_NORMAL;
            thresh_sel  <= `OMSM_THRESH_RESET;
            reset_limit <= 1'h0;
        end else begin
            mon_meta  <= {failsafe_strap_pin_in, wake_input_pin, main_supply_short,
                          severe_thermal_shutdown, battery_uv_timeout,
                          main_supply_undervoltage};
            mon_sync  <= mon_meta;
            wake_last <= wake;
            state     <= next_state;
            // Reset delay restarts on every entry and while the supply is low
            if (next_state != state || uv)
                rd_cnt <= RESET_DELAY_CYCLES;                         // RULE24 RULE21
            else if (rd_cnt != 32'h0)
                rd_cnt <= rd_cnt - 32'h1;
            if (next_state != state)
                released <= next_state[1] | next_state[2];
            else if (in_init)
                released <= ~uv & (released | (rd_cnt == 32'h0));     // RULE21
            // Strap level is taken at the reset release of init
            if (init_release)
                dev_mode <= ~strap;                                   // RULE9 RULE6
            if (init_release || (in_rst && next_state[1]) || refresh || wd_expire)
                wd_cnt <= (init_release || in_rst) ? LONG_WINDOW_CYCLES
                                                   : WD_PERIOD_CYCLES; // RULE14 RULE24
            else if (wd_run && wd_cnt != 32'h0)
                wd_cnt <= wd_cnt - 32'h1;
            if (refresh || wd_trip || init_release)
                miss_cnt <= 2'h0;
            else if (wd_expire)
                miss_cnt <= miss_cnt + 2'h1;
            if (refresh)
                rst_cnt <= 2'h0;
            else if (wd_reset && rst_cnt != `OMSM_RST_LIMIT_COUNT)
                rst_cnt <= rst_cnt + 2'h1;                            // RULE17
            if (in_rst || next_state[0])
                mode_sel <= `OMSM_MODE_NORMAL;                        // RULE8
            else if (mode_cmd)
                mode_sel <= fr_mode;
            if (cmd_ok && wr_hw)
                thresh_sel <= fr_data[`OMSM_HW_THRESH_BIT];           // RULE13
            if (cmd_ok && wr_wd)
                reset_limit <= fr_data[`OMSM_WD_LIMIT_BIT];           // RULE17
        end
    end

    // ****************************************
    // Status flags, set wins over clear
    // ****************************************
    wire clr_en = cmd_ok & wr_clr;

    always @(posedge clock) begin
        if (!resetn) begin
            spi_err   <= 1'h0;
            wd_fail   <= 1'h0;
            uv_flag   <= 1'h0;
            wk_flag   <= 1'h0;
            fs_active <= 1'h0;
        end else begin
            if (stop_rej || (frame_error && !in_init && !in_slp))
                spi_err <= 1'h1;                                      // RULE22 RULE23
            else if (clr_en && fr_data[`OMSM_CLR_SPI_BIT])
                spi_err <= 1'h0;
            if (wd_trip)
                wd_fail <= 1'h1;                                      // RULE16
            else if (clr_en && fr_data[`OMSM_CLR_WD_BIT])
                wd_fail <= 1'h0;
            if (uv && (in_norm || in_stop))
                uv_flag <= 1'h1;                                      // RULE20
            else if (clr_en && fr_data[`OMSM_CLR_UV_BIT])
                uv_flag <= 1'h0;
            if (wake_evt && !in_init)
                wk_flag <= 1'h1;                                      // RULE18
            else if (clr_en && fr_data[`OMSM_CLR_WAKE_BIT])
                wk_flag <= 1'h0;
            // Passing through restart leaves the outputs as they are
            if (!powerup && (wd_reset || next_state[5]))
                fs_active <= 1'h1;                                    // RULE11 RULE12 RULE20
            else if (clr_en && fr_data[`OMSM_CLR_FS_BIT] && !in_fs)
                fs_active <= 1'h0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reset_output_pin_n      = released;                        // RULE21
    assign main_regulator_output   = ~(in_slp | in_fs);               // RULE3 RULE4 RULE5
    assign low_power_stop          = in_stop;                         // RULE4
    assign current_mode            = state;
    assign operating_mode_select   = mode_sel;
    assign restart_threshold_state = thresh_sel;
    assign watchdog_halted         = dev_mode;
    assign failsafe_outputs        = fs_active;
    // Strap pin is input with pull-up in init, low-driving fail-safe output after
    assign failsafe_strap_pin_out  = 1'h0;
    assign failsafe_strap_pin_oe   = fs_active & ~in_init;            // RULE9
    assign strap_pullup_enable     = in_init;                         // RULE9
    assign spi_error_flag          = spi_err;
    assign watchdog_fail_flag      = wd_fail;
    assign undervoltage_flag       = uv_flag;
    assign wake_flag               = wk_flag;

endmodule // omsm_top
`default_nettype wire

/* tb/omsm_asserts.sv */
// Port assertions of the operating mode controller
`timescale 1ns/1ps
`default_nettype none
module omsm_asserts (
    input wire logic       clock, resetn, severe_thermal_shutdown, main_supply_short,
    input wire logic       reset_output_pin_n, main_regulator_output, low_power_stop,
    input wire logic       strap_pullup_enable, failsafe_strap_pin_oe, failsafe_outputs,
    input wire logic       watchdog_halted, watchdog_fail_flag, wake_flag,
    input wire logic [5:0] current_mode,
    input wire logic [2:0] operating_mode_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_stop_reg_on: assert property (current_mode == 6'h04 |-> main_regulator_output && low_power_stop)
        else $error("regulator off in stop");
    a_sleep_reg_off: assert property (current_mode == 6'h08 |-> !main_regulator_output)
        else $error("regulator on in sleep");
    a_failsafe_reg_off: assert property (current_mode == 6'h20 |-> !main_regulator_output)
        else $error("regulator on in fail-safe");
    // Two sync stages plus the state register
    a_fault_to_failsafe: assert property (severe_thermal_shutdown |-> ##[1:6] current_mode == 6'h20)
        else $error("no fail-safe after fault");
    a_init_strap_input: assert property (current_mode == 6'h01 |-> strap_pullup_enable && !failsafe_strap_pin_oe)
        else $error("strap pin not an input");
    a_restart_holds_reset: assert property ($past(current_mode == 6'h10) && current_mode == 6'h10 |-> !reset_output_pin_n)
        else $error("reset released in restart");
    a_restart_clears_sel: assert property ($past(current_mode == 6'h10) && current_mode == 6'h10 |-> operating_mode_select == 3'h0)
        else $error("mode field kept in restart");
    a_init_no_wake: assert property ($past(current_mode == 6'h01) && current_mode == 6'h01 |-> !$rose(wake_flag))
        else $error("wake recorded in init");
    a_init_no_failsafe: assert property (current_mode == 6'h01 && !reset_output_pin_n |-> !$rose(failsafe_outputs))
        else $error("fail-safe during power-up");
    a_dev_no_wd_fail: assert property (watchdog_halted |-> !$rose(watchdog_fail_flag))
        else $error("watchdog failure in development mode");
endmodule // omsm_asserts
bind omsm_top omsm_asserts u_chk (.*);
`default_nettype wire

/* tb/omsm_host_model.sv */
// Host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module omsm_host_model (
    output logic           spi_sck, spi_csn, spi_mosi,
    input wire logic       spi_miso, spi_miso_oe
);
    logic [15:0] rx;
    initial begin
        spi_sck = 0;
        spi_csn = 1;
        spi_mosi = 0;
    end
    // Mode 0, MSB first; clock stands low between frames
    task automatic xfer(input logic [15:0] w, input int n);
        rx = 16'h0;
        spi_csn = 0;
        #48;
        for (int i = 0; i < n; i++) begin
            spi_mosi = w[15-i];
            #24 spi_sck = 1;
            rx = {rx[14:0], spi_miso & spi_miso_oe};
            #24 spi_sck = 0;
        end
        #24 spi_csn = 1;
        // Released line must not look like held data
        spi_mosi = ~spi_mosi;
        #24;
    endtask
endmodule // omsm_host_model
`default_nettype wire

/* tb/omsm_top_tb.sv */
// Self-checking bench of the operating mode controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module omsm_top_tb;
    logic clock, resetn, spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe, strap;
    logic main_supply_undervoltage, battery_uv_timeout, severe_thermal_shutdown;
    logic main_supply_short, wake_input_pin, failsafe_strap_pin_in, failsafe_strap_pin_out;
    logic failsafe_strap_pin_oe, strap_pullup_enable, reset_output_pin_n, main_regulator_output;
    logic low_power_stop, restart_threshold_state, watchdog_halted, failsafe_outputs;
    logic spi_error_flag, watchdog_fail_flag, undervoltage_flag, wake_flag;
    logic [5:0] current_mode;
    logic [2:0] operating_mode_select;
    int miscompares = 0, compares = 0;
    localparam int RD = 20;
    assign failsafe_strap_pin_in = failsafe_strap_pin_oe ? failsafe_strap_pin_out : strap;
    omsm_top #(.RESET_DELAY_CYCLES(RD), .LONG_WINDOW_CYCLES(3000), .WD_PERIOD_CYCLES(2000)) DUT (.*);
    omsm_host_model host (.*);
    initial begin
        clock = 0;
        forever #2.5 clock = ~clock;
    end
    task automatic cyc(int n); repeat (n) @(negedge clock); endtask
    task automatic wr(logic [6:0] a, logic [7:0] d); host.xfer({1'b1, a, d}, 16); cyc(8); endtask
    task automatic wake; wake_input_pin = 1; cyc(4); wake_input_pin = 0; cyc(4); endtask
    task automatic wait_mode(logic [5:0] m, int lim);
        for (int i = 0; i < lim && current_mode !== m; i++) cyc(1);
        `CHK("mode", m, current_mode)
    endtask
    task automatic stop_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic boot(logic s);
        resetn = 0; main_supply_undervoltage = 1; strap = s; cyc(5); resetn = 1; cyc(30);
        `CHK("rst_n", 1'b0, reset_output_pin_n)
        `CHK("mode", 6'h01, current_mode)
        main_supply_undervoltage = 0; cyc(RD - 4);
        `CHK("rst_n", 1'b0, reset_output_pin_n)
        cyc(10);
        `CHK("rst_n", 1'b1, reset_output_pin_n)
        `CHK("dev", ~s, watchdog_halted)
    endtask
    task automatic t_init;
        boot(1); wake;
        `CHK("wake", 1'b0, wake_flag)
        `CHK("fs", 1'b0, failsafe_outputs)
        `CHK("uv", 1'b0, undervoltage_flag)
        host.xfer(16'h7f55, 16); cyc(8);
        `CHK("mode", 6'h02, current_mode)
        $display("init done");
    endtask
    task automatic t_stop;
        wr(7'h02, 8'h01);
        wr(7'h01, 8'h02);
        `CHK("mode", 6'h04, current_mode)
        wr(7'h03, 8'h00);
        `CHK("err", 1'b1, spi_error_flag)
        `CHK("thr", 1'b1, restart_threshold_state)
        wr(7'h05, 8'h01);
        `CHK("err", 1'b0, spi_error_flag)
        wr(7'h01, 8'h01);
        `CHK("err", 1'b1, spi_error_flag)
        `CHK("mode", 6'h10, current_mode)
        `CHK("sel", 3'h0, operating_mode_select)
        wait_mode(6'h02, RD + 10);
        $display("stop done");
    endtask
    task automatic t_sleep_fail;
        wr(7'h01, 8'h01);
        `CHK("mode", 6'h08, current_mode)
        wake; wait_mode(6'h02, RD + 30);
        severe_thermal_shutdown = 1; cyc(8);
        `CHK("mode", 6'h20, current_mode)
        wake;
        `CHK("mode", 6'h20, current_mode)
        severe_thermal_shutdown = 0; wake; wait_mode(6'h02, RD + 30);
        wr(7'h05, 8'h10);
        `CHK("fs", 1'b0, failsafe_outputs)
        $display("sleep and fail-safe done");
    endtask
    task automatic t_wd;
        wait_mode(6'h10, 3100);
        `CHK("rst_n", 1'b0, reset_output_pin_n)
        `CHK("wdf", 1'b1, watchdog_fail_flag)
        `CHK("fs", 1'b1, failsafe_outputs)
        `CHK("reg", 1'b1, main_regulator_output)
        wait_mode(6'h02, RD + 10);
        wr(7'h03, 8'h00);
        `CHK("thr", 1'b0, restart_threshold_state)
        cyc(3100);
        `CHK("mode", 6'h02, current_mode)
        wait_mode(6'h10, 2100);
        wait_mode(6'h02, RD + 10);
        wr(7'h03, 8'h01);
        wr(7'h02, 8'h03);
        repeat (3) begin wait_mode(6'h10, 3100); wait_mode(6'h02, RD + 10); end
        cyc(3300);
        `CHK("mode", 6'h02, current_mode)
        `CHK("rst_n", 1'b1, reset_output_pin_n)
        wr(7'h01, 8'h03);
        `CHK("mode", 6'h01, current_mode)
        $display("watchdog done");
    endtask
    task automatic t_dev;
        boot(0); host.xfer(16'h0000, 16); cyc(8);
        `CHK("mode", 6'h02, current_mode)
        cyc(3500);
        `CHK("mode", 6'h02, current_mode)
        `CHK("wdf", 1'b0, watchdog_fail_flag)
        $display("development done");
    endtask
    initial begin
        resetn = 0; strap = 1; battery_uv_timeout = 0; severe_thermal_shutdown = 0;
        main_supply_short = 0; wake_input_pin = 0; main_supply_undervoltage = 1;
        t_init; t_stop; t_sleep_fail; t_wd; t_dev;
        stop_test;
    end
    initial begin
        #300000;
        miscompares++;
        stop_test;
    end
endmodule // omsm_top_tb
`default_nettype wire
